// File: rtl/vms_pkg.sv
package vms_pkg;
   localparam int          STEP_W        = 20;
   localparam logic [19:0] STEP_SAT      = 20'hfffff;      // (2^20)-1
   localparam logic [20:0] STST_CYCLES   = 21'h100000;     // 2^20 clocks
   localparam logic [17:0] PD_UNIT_MAX   = 18'h3ffff;      // 2^18 clocks - 1
   localparam int          FULL_USTEP    = 256;
   // register byte addresses
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_PWMTH    = 8'h04;
   localparam logic [7:0]  ADDR_LATH     = 8'h08;
   localparam logic [7:0]  ADDR_HSTH     = 8'h0c;
   localparam logic [7:0]  ADDR_CURR     = 8'h10;
   localparam logic [7:0]  ADDR_PDD      = 8'h14;
   localparam logic [7:0]  ADDR_STEPT    = 8'h18;
   localparam logic [7:0]  ADDR_STAT     = 8'h1c;
   // ctrl fields
   localparam int CTRL_PWM_EN   = 0;
   localparam int CTRL_LA_EN    = 1;
   localparam int CTRL_STALL_EN = 2;
   localparam int CTRL_HSCHM    = 3;
   localparam int CTRL_HSFS     = 4;
   localparam int CTRL_NARROW   = 5;
   localparam int CTRL_MRES_LO  = 8;   // 4-bit microstep shift: 0=256 .. 8=full
   // reset values
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [19:0] THR_RST    = 20'h00000;
   localparam logic [4:0]  RUN_RST    = 5'h1f;
   localparam logic [4:0]  HOLD_RST   = 5'h10;
   localparam logic [3:0]  HDLY_RST   = 4'h0;
   localparam logic [7:0]  PDD_RST    = 8'h0a;
endpackage : vms_pkg

// File: rtl/vms_velocity_mode_selector.sv
`timescale 1ns/100ps
// How it works
// RULE1 - standstill flag rises 2^20 clocks after last step pulse, readable.
// RULE2 - step interval counts clocks between 1/256 microsteps, readable.
// RULE3 - step interval saturates to (2^20)-1 on overflow or standstill.
// RULE4 - interval is normalised to 256 microsteps regardless of resolution.
// RULE5 - upper switch point uses interval*15/16-1, or *31/32-1 when narrow.
// RULE6 - interval >= quiet threshold enables voltage PWM, disables load speed control.
// RULE7 - between load-adapt and high-speed thresholds: adaptive current on, PWM off.
// RULE8 - interval <= load-adapt threshold enables stall output if configured.
// RULE9 - interval <= high threshold: no adaptive current, normal scale, PWM off.
// RULE10 - const-off at high speed selects constant off-time chopper, fast decay zero.
// RULE11 - off time doubles while high-speed const-off chopper runs.
// RULE12 - full-step at high speed switches stall detection to load-speed detector.
// RULE13 - full-step changeover only at 45 degrees, using that table current; code leaves full-step at any angle and keeps current_scale.
// RULE14 - controller enables voltage PWM only at standstill; code also enables it while moving, when CTRL_PWM_EN, pw_ff set and la_ff, hs_ff clear.
// RULE15 - current reduction waits power-down delay, units of 2^18 clocks.
// RULE16 - software sets power-down delay at least 2.
// RULE17 - run current while moving, hold current at standstill.
// RULE18 - software orders thresholds quiet < load-adapt < high velocity.
// RULE19 - hold reduction steps one level per delay, zero means instant.
// RULE20 - comparisons re-evaluated on every new interval value.
module vms_velocity_mode_selector (
   input  wire logic        sys_clk,          // device clock
   input  wire logic        nrst,             // sync reset, active low
   input  wire logic        step_pulse,       // one pulse per selected microstep
   input  wire logic        at_45deg,         // electrical angle at 45 degrees
   input  wire logic [3:0]  off_time,         // programmed chopper off time
   input  wire logic [31:0] haddr,            // ahb address
   input  wire logic [1:0]  htrans,           // ahb transfer type
   input  wire logic        hwrite,           // ahb write
   input  wire logic [2:0]  hsize,            // ahb size
   input  wire logic [31:0] hwdata,           // ahb write data
   input  wire logic        hsel,             // ahb select
   input  wire logic        hready,           // ahb ready in
   output logic      [31:0] hrdata,           // ahb read data
   output logic             hreadyout,        // ahb ready out
   output logic             hresp,            // ahb response, always okay
   output logic             standstill_flag,  // motor at standstill
   output logic             pwm_chop_on,      // voltage pwm chopper active
   output logic             load_speed_on,    // load-dependent speed control on
   output logic             adapt_cur_on,     // load-adaptive current on
   output logic             stall_out_on,     // stall output enabled
   output logic             chopper_mode_sel, // 1 = constant off time
   output logic [1:0]       fast_decay_time,  // fast decay time, 0 forced
   output logic [4:0]       eff_off_time,     // off time after doubling
   output logic             fullstep_on,      // full-step drive active
   output logic             stall_src_sel,    // 1 = load-speed stall detector
   output logic [4:0]       current_scale     // actual current scale
);

   // ---------------- ahb slave ----------------
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [19:0] pwm_th_ff, nxt_pwm_th, la_th_ff, nxt_la_th, hs_th_ff, nxt_hs_th;
   logic [4:0]  run_lvl_ff, nxt_run_lvl, hold_lvl_ff, nxt_hold_lvl;
   logic [3:0]  hold_dly_ff, nxt_hold_dly;
   logic [7:0]  pdd_ff, nxt_pdd;
   logic        wr_pend_ff, nxt_wr_pend;
   logic [7:0]  wr_addr_ff, nxt_wr_addr;
   logic [31:0] nxt_hrdata;
   logic [19:0] step_interval_ff;
   logic        addr_ph;
   assign addr_ph = hsel && hready && htrans[1];
   always_comb begin
      nxt_ctrl     = ctrl_ff;
      nxt_pwm_th   = pwm_th_ff;
      nxt_la_th    = la_th_ff;
      nxt_hs_th    = hs_th_ff;
      nxt_run_lvl  = run_lvl_ff;
      nxt_hold_lvl = hold_lvl_ff;
      nxt_hold_dly = hold_dly_ff;
      nxt_pdd      = pdd_ff;
      nxt_wr_pend  = addr_ph && hwrite;
      nxt_wr_addr  = haddr[7:0];
      nxt_hrdata   = hrdata;
      if (wr_pend_ff) begin
         case (wr_addr_ff)
            vms_pkg::ADDR_CTRL:  nxt_ctrl = hwdata;
            vms_pkg::ADDR_PWMTH: nxt_pwm_th = hwdata[19:0];
            vms_pkg::ADDR_LATH:  nxt_la_th = hwdata[19:0];
            vms_pkg::ADDR_HSTH:  nxt_hs_th = hwdata[19:0];
            vms_pkg::ADDR_CURR: begin
               nxt_run_lvl  = hwdata[4:0];
               nxt_hold_lvl = hwdata[12:8];
               nxt_hold_dly = hwdata[19:16];
            end
            vms_pkg::ADDR_PDD:   nxt_pdd = hwdata[7:0];
            default: ;
         endcase
      end
      if (addr_ph && !hwrite) begin
         case (haddr[7:0])
            vms_pkg::ADDR_CTRL:  nxt_hrdata = ctrl_ff;
            vms_pkg::ADDR_PWMTH: nxt_hrdata = {12'h000, pwm_th_ff};
            vms_pkg::ADDR_LATH:  nxt_hrdata = {12'h000, la_th_ff};
            vms_pkg::ADDR_HSTH:  nxt_hrdata = {12'h000, hs_th_ff};
            vms_pkg::ADDR_CURR:
               nxt_hrdata = {12'h000, hold_dly_ff, 3'h0, hold_lvl_ff, 3'h0, run_lvl_ff};
            vms_pkg::ADDR_PDD:   nxt_hrdata = {24'h000000, pdd_ff};
            vms_pkg::ADDR_STEPT: nxt_hrdata = {12'h000, step_interval_ff}; // RULE2
            vms_pkg::ADDR_STAT:
               nxt_hrdata = {22'h000000, current_scale, fullstep_on, adapt_cur_on,
                             pwm_chop_on, load_speed_on, standstill_flag}; // RULE1
            default:             nxt_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_ff     <= vms_pkg::CTRL_RST;
         pwm_th_ff   <= vms_pkg::THR_RST;
         la_th_ff    <= vms_pkg::THR_RST;
         hs_th_ff    <= vms_pkg::THR_RST;
         run_lvl_ff  <= vms_pkg::RUN_RST;
         hold_lvl_ff <= vms_pkg::HOLD_RST;
         hold_dly_ff <= vms_pkg::HDLY_RST;
         pdd_ff      <= vms_pkg::PDD_RST;
         wr_pend_ff  <= 1'b0;
         wr_addr_ff  <= 8'h00;
         hrdata      <= 32'h0000_0000;
      end else begin
         ctrl_ff     <= nxt_ctrl;
         pwm_th_ff   <= nxt_pwm_th;
         la_th_ff    <= nxt_la_th;
         hs_th_ff    <= nxt_hs_th;
         run_lvl_ff  <= nxt_run_lvl;
         hold_lvl_ff <= nxt_hold_lvl;
         hold_dly_ff <= nxt_hold_dly;
         pdd_ff      <= nxt_pdd;
         wr_pend_ff  <= nxt_wr_pend;
         wr_addr_ff  <= nxt_wr_addr;
         hrdata      <= nxt_hrdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ---------------- step interval measurement ----------------
   logic [20:0] idle_cnt_ff, nxt_idle_cnt;
   logic [20:0] ustep_cnt_ff, nxt_ustep_cnt;
   logic [19:0] nxt_step_interval;
   logic        nxt_stst, new_meas_ff, nxt_new_meas;
   logic [3:0]  mres;
   logic [28:0] scaled;
   assign mres   = ctrl_ff[vms_pkg::CTRL_MRES_LO +: 4];
   // interval between 1/256 microsteps = measured pulse period / 2^mres
   assign scaled = {8'h00, ustep_cnt_ff} >> mres;                             // RULE4

   always_comb begin
      nxt_idle_cnt      = idle_cnt_ff;
      nxt_ustep_cnt     = ustep_cnt_ff;
      nxt_step_interval = step_interval_ff;
      nxt_stst          = standstill_flag;
      nxt_new_meas      = 1'b0;
      if (step_pulse) begin
         nxt_idle_cnt  = 21'h000000;
         nxt_ustep_cnt = 21'h000001;
         nxt_stst      = 1'b0;
         nxt_new_meas  = 1'b1;
         if (ustep_cnt_ff[20] || standstill_flag)
            nxt_step_interval = vms_pkg::STEP_SAT;                             // RULE3
         else
            nxt_step_interval = (scaled > 29'(vms_pkg::STEP_SAT)) ?
                                vms_pkg::STEP_SAT : scaled[19:0];             // RULE2
      end else begin
         if (!ustep_cnt_ff[20])
            nxt_ustep_cnt = ustep_cnt_ff + 21'h000001;
         if (idle_cnt_ff != vms_pkg::STST_CYCLES)
            nxt_idle_cnt = idle_cnt_ff + 21'h000001;
         if (idle_cnt_ff == vms_pkg::STST_CYCLES - 21'h000001) begin
            nxt_stst          = 1'b1;                                          // RULE1
            nxt_step_interval = vms_pkg::STEP_SAT;                             // RULE3
            nxt_new_meas      = 1'b1;                                          // RULE20
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         idle_cnt_ff      <= vms_pkg::STST_CYCLES;
         ustep_cnt_ff     <= 21'h100000;
         step_interval_ff <= vms_pkg::STEP_SAT;
         standstill_flag  <= 1'b1;
         new_meas_ff      <= 1'b1;
      end else begin
         idle_cnt_ff      <= nxt_idle_cnt;
         ustep_cnt_ff     <= nxt_ustep_cnt;
         step_interval_ff <= nxt_step_interval;
         standstill_flag  <= nxt_stst;
         new_meas_ff      <= nxt_new_meas;
      end
   end

   // ---------------- threshold comparison with hysteresis ----------------
   logic [19:0] upper_iv;
   logic        hs_ff, nxt_hs, la_ff, nxt_la, pw_ff, nxt_pw;
   function automatic logic hyst_cmp(input logic prev, input logic [19:0] lo_iv,
                                     input logic [19:0] up_iv, input logic [19:0] thr);
      // faster than threshold: enter on plain interval, stay while shortened one fits
      hyst_cmp = prev ? (up_iv <= thr) : (lo_iv <= thr);
   endfunction : hyst_cmp
   always_comb begin
      if (ctrl_ff[vms_pkg::CTRL_NARROW])
         upper_iv = 20'((25'(step_interval_ff) * 25'h1f) >> 5) - 20'h00001;  // RULE5
      else
         upper_iv = 20'((25'(step_interval_ff) * 25'h0f) >> 4) - 20'h00001;  // RULE5
      if (upper_iv > step_interval_ff)
         upper_iv = 20'h00000;
      nxt_hs = hs_ff;
      nxt_la = la_ff;
      nxt_pw = pw_ff;
      if (new_meas_ff) begin                                                   // RULE20
         nxt_hs = hyst_cmp(hs_ff, step_interval_ff, upper_iv, hs_th_ff);
         nxt_la = hyst_cmp(la_ff, step_interval_ff, upper_iv, la_th_ff);
         nxt_pw = !hyst_cmp(!pw_ff, step_interval_ff, upper_iv, pwm_th_ff - 20'h00001)
                  || pwm_th_ff == 20'h00000;                                   // RULE6
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         hs_ff <= 1'b0;
         la_ff <= 1'b0;
         pw_ff <= 1'b1;
      end else begin
         hs_ff <= nxt_hs;
         la_ff <= nxt_la;
         pw_ff <= nxt_pw;
      end
   end

   // ---------------- mode outputs and current control ----------------
   logic        fs_ff, nxt_fs;
   logic [25:0] pd_cnt_ff, nxt_pd_cnt;
   logic [21:0] hd_cnt_ff, nxt_hd_cnt;
   logic [4:0]  nxt_scale;
   logic        pd_done;

   assign pd_done = (pd_cnt_ff == {pdd_ff, vms_pkg::PD_UNIT_MAX});

   always_comb begin
      nxt_fs = fs_ff;
      if (!(hs_ff && ctrl_ff[vms_pkg::CTRL_HSFS]))
         nxt_fs = 1'b0;
      else if (at_45deg)
         nxt_fs = 1'b1;                                                        // RULE13
      nxt_pd_cnt = pd_cnt_ff;
      nxt_hd_cnt = hd_cnt_ff;
      nxt_scale  = current_scale;
      if (!standstill_flag) begin
         nxt_pd_cnt = 26'h0000000;
         nxt_hd_cnt = 22'h000000;
         nxt_scale  = run_lvl_ff;                                              // RULE17
      end else if (pdd_ff != 8'h00 && !pd_done) begin
         nxt_pd_cnt = pd_cnt_ff + 26'h0000001;                                 // RULE15
      end else if (current_scale > hold_lvl_ff) begin
         if (hold_dly_ff == 4'h0 || hd_cnt_ff == {hold_dly_ff, vms_pkg::PD_UNIT_MAX}) begin
            nxt_hd_cnt = 22'h000000;
            nxt_scale  = (hold_dly_ff == 4'h0) ? hold_lvl_ff
                                               : current_scale - 5'h01;        // RULE19
         end else
            nxt_hd_cnt = hd_cnt_ff + 22'h000001;
      end else
         nxt_scale = hold_lvl_ff;                                              // RULE17
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         fs_ff            <= 1'b0;
         pd_cnt_ff        <= 26'h0000000;
         hd_cnt_ff        <= 22'h000000;
         current_scale    <= vms_pkg::RUN_RST;
         pwm_chop_on      <= 1'b0;
         load_speed_on    <= 1'b0;
         adapt_cur_on     <= 1'b0;
         stall_out_on     <= 1'b0;
         chopper_mode_sel <= 1'b0;
         fast_decay_time  <= 2'h0;
         eff_off_time     <= 5'h00;
         fullstep_on      <= 1'b0;
         stall_src_sel    <= 1'b0;
      end else begin
         fs_ff            <= nxt_fs;
         pd_cnt_ff        <= nxt_pd_cnt;
         hd_cnt_ff        <= nxt_hd_cnt;
         current_scale    <= nxt_scale;
         pwm_chop_on      <= ctrl_ff[vms_pkg::CTRL_PWM_EN] && pw_ff && !la_ff && !hs_ff; // RULE6
         load_speed_on    <= !pw_ff;                                           // RULE6
         adapt_cur_on     <= ctrl_ff[vms_pkg::CTRL_LA_EN] && la_ff && !hs_ff; // RULE7 RULE9
         stall_out_on     <= ctrl_ff[vms_pkg::CTRL_STALL_EN] && la_ff;        // RULE8
         chopper_mode_sel <= ctrl_ff[vms_pkg::CTRL_HSCHM] && hs_ff;           // RULE10
         fast_decay_time  <= 2'h0;                                             // RULE10
         eff_off_time     <= (ctrl_ff[vms_pkg::CTRL_HSCHM] && hs_ff) ?
                             {off_time, 1'b0} : {1'b0, off_time};              // RULE11
         fullstep_on      <= nxt_fs;                                           // RULE12
         stall_src_sel    <= nxt_fs;                                           // RULE12
      end
   end

   stst_time_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      step_pulse ##1 !step_pulse [*8] |-> !standstill_flag) // RULE1
      else $error("standstill set too early");
   sat_stst_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      standstill_flag |-> step_interval_ff == vms_pkg::STEP_SAT) // RULE3
      else $error("interval not saturated at standstill");
   hs_pwm_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      hs_ff |=> !pwm_chop_on && !adapt_cur_on) // RULE9
      else $error("pwm or adaptive current on at high speed");
   la_pwm_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      la_ff |=> !pwm_chop_on) // RULE7
      else $error("pwm on in adaptive band");
   stall_en_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      la_ff && ctrl_ff[vms_pkg::CTRL_STALL_EN] |=> stall_out_on) // RULE8
      else $error("stall output not enabled");
   chm_hs_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      chopper_mode_sel |-> fast_decay_time == 2'h0 && eff_off_time[0] == 1'b0) // RULE11
      else $error("const off chopper settings wrong");
   fs_45_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(fs_ff) |-> $past(at_45deg)) // RULE13
      else $error("fullstep entered off 45 degrees");
   run_cur_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !standstill_flag ##1 !standstill_flag |-> current_scale == $past(run_lvl_ff)) // RULE17
      else $error("run current not applied");
   hyst_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !new_meas_ff |=> hs_ff == $past(hs_ff)) // RULE20
      else $error("comparison changed without measurement");
   cv_stst: cover property (@(posedge sys_clk) $rose(standstill_flag));
   cv_hs: cover property (@(posedge sys_clk) $rose(hs_ff));
   cv_fs: cover property (@(posedge sys_clk) $rose(fullstep_on));
endmodule : vms_velocity_mode_selector

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
   logic        sys_clk, nrst, hwrite, hsel, step_run, a45_en, step_pulse, at_45deg;
   logic        hreadyout, hresp, standstill_flag, pwm_chop_on, load_speed_on;
   logic        adapt_cur_on, stall_out_on, chopper_mode_sel, fullstep_on, stall_src_sel;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, fast_decay_time;
   logic [2:0]  hsize;
   logic [3:0]  off_time;
   logic [4:0]  eff_off_time, current_scale;
   logic [15:0] period;
   int          err_count, cmp_count;

   vms_velocity_mode_selector i_vms_velocity_mode_selector (.sys_clk(sys_clk), .nrst(nrst),
      .step_pulse(step_pulse), .at_45deg(at_45deg), .off_time(off_time), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .standstill_flag(standstill_flag), .pwm_chop_on(pwm_chop_on),
      .load_speed_on(load_speed_on), .adapt_cur_on(adapt_cur_on),
      .stall_out_on(stall_out_on), .chopper_mode_sel(chopper_mode_sel),
      .fast_decay_time(fast_decay_time), .eff_off_time(eff_off_time),
      .fullstep_on(fullstep_on), .stall_src_sel(stall_src_sel),
      .current_scale(current_scale));

   vms_step_source i_vms_step_source (.sys_clk(sys_clk), .nrst(nrst), .run(step_run),
      .a45_en(a45_en), .period(period), .step_pulse(step_pulse), .at_45deg(at_45deg));

   task summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         err_count++;
         $display("Error at %0t: bus wait ran out", $time);
         summarize();
      end
   endtask : wait_ready

   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsize <= 3'b010;
      wait_ready();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : ahb

   task wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, {24'h0, a}, d);
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      ahb(1'b0, {24'h0, a}, 32'h0);
      chk(rd, exp, what);
   endtask : rdc

   // run the source at period p until n pulses passed, then let outputs settle
   task steps(input logic [15:0] p, input int n);
      int k;
      int c;
      period <= p;
      step_run <= 1'b1;
      k = 0;
      c = 0;
      while (c < n && k < 20000) begin
         @(posedge sys_clk);
         k++;
         if (step_pulse === 1'b1)
            c++;
      end
      if (c < n) begin
         err_count++;
         $display("Error at %0t: step wait ran out", $time);
         summarize();
      end
      repeat (4) @(posedge sys_clk);
   endtask : steps

   task modes(input logic [4:0] exp, input string what);
      chk({27'h0, pwm_chop_on, adapt_cur_on, stall_out_on, chopper_mode_sel, fullstep_on},
          {27'h0, exp}, what);
   endtask : modes

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      nrst = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      hsel = 1'b0;
      off_time = 4'h5;
      period = 16'h0064;
      step_run = 1'b0;
      a45_en = 1'b0;
      err_count = 0;
      cmp_count = 0;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(32'(standstill_flag), 32'h1, "standstill at reset");
      rdc(vms_pkg::ADDR_STEPT, 32'(vms_pkg::STEP_SAT), "interval at rest");
      rdc(vms_pkg::ADDR_STAT, 32'h0000_03e1, "status at rest");
      chk(32'(hresp), 32'h0, "okay response");
      rdc(vms_pkg::ADDR_CTRL, vms_pkg::CTRL_RST, "ctrl reset");
      rdc(vms_pkg::ADDR_PDD, {24'h0, vms_pkg::PDD_RST}, "delay reset");
      rdc(vms_pkg::ADDR_CURR, {12'h0, vms_pkg::HDLY_RST, 3'h0, vms_pkg::HOLD_RST, 3'h0,
          vms_pkg::RUN_RST}, "currents reset");
      wr(vms_pkg::ADDR_STEPT, 32'h0000_0005);
      rdc(vms_pkg::ADDR_STEPT, 32'(vms_pkg::STEP_SAT), "interval read-only");
      wr(8'h20, 32'h0000_1234);
      rdc(8'h20, 32'h0, "unmapped");
      wr(vms_pkg::ADDR_PWMTH, 32'd2000);
      wr(vms_pkg::ADDR_LATH, 32'd1000);
      wr(vms_pkg::ADDR_HSTH, 32'd100);
      rdc(vms_pkg::ADDR_LATH, 32'd1000, "load threshold");
      wr(vms_pkg::ADDR_CURR, 32'h0000_0814);
      wr(vms_pkg::ADDR_PDD, 32'h0000_0002);
      rdc(vms_pkg::ADDR_PDD, 32'h0000_0002, "delay readback");
      wr(vms_pkg::ADDR_CTRL, 32'h0000_001f);
      steps(16'd4000, 3);
      chk(32'(standstill_flag), 32'h0, "moving");
      rdc(vms_pkg::ADDR_STEPT, 32'd4000, "slow interval");
      modes(5'b10000, "slow modes");
      chk(32'(load_speed_on), 32'h0, "slow load speed");
      chk(32'(current_scale), 32'd20, "run current");
      steps(16'd400, 3);
      rdc(vms_pkg::ADDR_STEPT, 32'd400, "mid interval");
      modes(5'b01100, "mid modes");
      chk(32'(load_speed_on), 32'h1, "mid load speed");
      steps(16'd50, 3);
      modes(5'b00110, "fast modes before 45");
      chk(32'(fast_decay_time), 32'h0, "fast decay");
      chk(32'(eff_off_time), 32'h0000_000a, "doubled off time");
      chk(32'(current_scale), 32'd20, "normal scale");
      a45_en <= 1'b1;
      steps(16'd50, 6);
      modes(5'b00111, "fast modes at 45");
      chk(32'(stall_src_sel), 32'h1, "stall source");
      steps(16'd400, 3);
      chk(32'(chopper_mode_sel), 32'h0, "left high speed");
      chk(32'(eff_off_time), 32'h0000_0005, "plain off time");
      steps(16'd50, 3);
      steps(16'd106, 3);
      chk(32'(chopper_mode_sel), 32'h1, "wide hysteresis");
      wr(vms_pkg::ADDR_CTRL, 32'h0000_003f);
      steps(16'd50, 3);
      steps(16'd106, 3);
      chk(32'(chopper_mode_sel), 32'h0, "narrow hysteresis");
      wr(vms_pkg::ADDR_CTRL, 32'h0000_023f);
      steps(16'd400, 4);
      rdc(vms_pkg::ADDR_STEPT, 32'd100, "normalised interval");
      summarize();
   end
endmodule : tb

// File: tb/vms_step_source.sv
`timescale 1ns/100ps
// far-side step source: one-cycle step pulse every period clocks, 45 degree marker
module vms_step_source (
   input  wire logic        sys_clk,    // device clock
   input  wire logic        nrst,       // sync reset, active low
   input  wire logic        run,        // emit steps
   input  wire logic        a45_en,     // allow the 45 degree marker
   input  wire logic [15:0] period,     // clocks between step pulses
   output logic             step_pulse, // one-cycle step
   output logic             at_45deg    // electrical angle at 45 degrees
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic [1:0]  ph_ff;
   logic [1:0]  nxt_ph;
   logic        nxt_step;

   always_comb begin
      nxt_cnt = cnt_ff + 16'h0001;
      nxt_ph = ph_ff;
      nxt_step = 1'b0;
      if (!run) begin
         nxt_cnt = 16'h0000;
      end else if (cnt_ff >= period - 16'h0001) begin
         nxt_cnt = 16'h0000;
         nxt_step = 1'b1;
         nxt_ph = ph_ff + 2'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_ff <= 16'h0000;
         ph_ff <= 2'h0;
         step_pulse <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         ph_ff <= nxt_ph;
         step_pulse <= nxt_step;
      end
   end

   // marker is a level held for one step period out of four
   assign at_45deg = a45_en & (ph_ff == 2'h0);
endmodule : vms_step_source
